// file: pcm_stage_pkg.sv
// How it works
// - Interrupt output is the OR of all masked event view bits.
// - A receive event sets its status bit whatever the enable mask holds.
// - Masked view bit equals status bit AND enable bit.
// - Enable bit 1 lets an event reach the interrupt, 0 blocks it.
// - Writing 1 to the force register sets the matching status bit.
// - Level event fires while FIFO entries exceed the programmed threshold.
// - Not-empty event fires while the FIFO holds at least one word.
// - Sample arriving at a full FIFO raises overflow; later samples are dropped.
// - Reading the FIFO read register while empty raises underflow.
// - Status bits stay set until software clears them; FIFO reads never clear.
// - Writing 1 to a status bit clears it; interrupt holds until then.
// - Independent left and right gain codes, 1.5 dB steps, changeable live.
// - Smoother moves in fine steps, size picked by one select bit.
// - Smoother waits 64 to 512 sample periods between fine steps.
// - Soft mute ramps output down to silence with the same fine stepping.
// - Muted stream still pushes samples; unmute ramps back to channel gain.
// - Word width 16, 18, 20 or 24 bits, right aligned in 32-bit words.
// - Unused upper bits hold sign copies or zeros per extension bit.
// - DC blocking filter runs when its disable bit is 0, bypassed at 1.
// - Filter: y = x - x1 + (1 - 2^-G) y1, G a 4-bit field reset to 0xB.
// - Samples are converted and pushed only while the run bit is set.
// - Every FIFO read register read of a non-empty FIFO advances the FIFO read pointer once.
package pcm_stage_pkg;

    // ==========================================================
    // Register byte addresses
    localparam logic [7:0] ADDR_CONVERTER_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_MODE_CONFIG       = 8'h04;
    localparam logic [7:0] ADDR_DATA_FORMAT       = 8'h08;
    localparam logic [7:0] ADDR_FIFO_CONTROL      = 8'h0C;
    localparam logic [7:0] ADDR_EVENT_STATUS      = 8'h10;
    localparam logic [7:0] ADDR_EVENT_FORCE       = 8'h14;
    localparam logic [7:0] ADDR_EVENT_ENABLE      = 8'h18;
    localparam logic [7:0] ADDR_MASKED_VIEW       = 8'h1C;
    localparam logic [7:0] ADDR_FIFO_READ         = 8'h20;

    // ==========================================================
    // Field positions
    localparam int RUN_BIT       = 0;
    localparam int MUTE_BIT      = 1;
    localparam int STEP_SEL_BIT  = 2;
    localparam int LEFT_GAIN_LSB = 4;
    localparam int RIGHT_GAIN_LSB = 8;
    localparam int DC_DIS_BIT    = 0;
    localparam int COEFF_LSB     = 4;
    localparam int TSTEP_LSB     = 8;
    localparam int WIDTH_LSB     = 0;
    localparam int SIGN_EXT_BIT  = 2;

    // Event bit positions
    localparam int EV_LEVEL     = 0;
    localparam int EV_NOT_EMPTY = 1;
    localparam int EV_OVERFLOW  = 2;
    localparam int EV_UNDERFLOW = 3;
    localparam int EV_COUNT     = 4;

    // ==========================================================
    // Reset values
    localparam logic [3:0] COEFF_RESET     = 4'hB;
    localparam logic [3:0] GAIN_CODE_RESET = 4'h8;
    localparam logic [2:0] TSTEP_RESET     = 3'h0;
    localparam logic [1:0] WIDTH_RESET     = 2'h3;
    localparam logic [7:0] THRESH_RESET    = 8'h7F;

    // ==========================================================
    // Gain scale: index counts eighth-dB units, 192 is unity gain
    localparam logic [8:0] GAIN_IDX_BASE   = 9'h05C;
    localparam logic [8:0] GAIN_IDX_PER_CODE = 9'h00C;
    localparam logic [8:0] GAIN_IDX_MUTE   = 9'h000;
    localparam logic [8:0] GAIN_IDX_OCTAVE = 9'h030;
    localparam logic [16:0] MANT_SCALE     = 17'h00555;
    localparam int          MULT_FRAC      = 16;
    localparam int          SAMPLE_W       = 24;
    localparam int          TSTEP_UNIT     = 64;

endpackage

// file: pcm_output_stage.sv
`timescale 1ns/1ps
`default_nettype none
module pcm_output_stage
    import pcm_stage_pkg::*;
#(
    parameter int FIFO_DEPTH = 256,
    parameter int LEVEL_W    = 9
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                sample_valid,
    input  wire logic                sample_right,
    input  wire logic [SAMPLE_W-1:0] sample_data,
    input  wire logic [LEVEL_W-1:0]  fifo_level,
    input  wire logic [31:0]         fifo_rdata,
    output logic                     fifo_push,
    output logic      [31:0]         fifo_wdata,
    output logic                     fifo_pop,
    output logic                     irq
);

    // ==========================================================
    // Helpers
    function automatic logic [8:0] target_idx(input logic [3:0] code);
        logic [12:0] p;
        p = GAIN_IDX_PER_CODE * code;
        return GAIN_IDX_BASE + p[8:0];
    endfunction

    // Linear multiplier in Q16; mantissa is linear within each octave,
    // which keeps the table out at the cost of just over half a dB of error.
    function automatic logic [18:0] gain_mult(input logic [8:0] idx);
        logic [8:0]  oct;
        logic [8:0]  rem;
        logic [25:0] mant;
        oct  = idx / GAIN_IDX_OCTAVE;
        rem  = idx % GAIN_IDX_OCTAVE;
        mant = 26'((GAIN_IDX_OCTAVE + rem) * MANT_SCALE);
        mant = mant << oct[2:0];
        return mant[22:4];
    endfunction

    function automatic logic [8:0] step_toward(input logic [8:0] cur,
                                               input logic [8:0] tgt,
                                               input logic [8:0] stp);
        if (cur < tgt) begin
            return (tgt - cur > stp) ? cur + stp : tgt;
        end else if (cur > tgt) begin
            return (cur - tgt > stp) ? cur - stp : tgt;
        end
        return cur;
    endfunction

    function automatic logic signed [23:0] sat24(input logic signed [33:0] v);
        if (v > 34'sd8388607) begin
            return 24'sh7FFFFF;
        end else if (v < -34'sd8388608) begin
            return 24'sh800000;
        end
        return v[23:0];
    endfunction

    function automatic logic [31:0] format_word(input logic signed [23:0] s,
                                                input logic [1:0] wsel,
                                                input logic ext);
        logic [4:0]  w;
        logic [31:0] sh;
        logic [31:0] mask;
        unique case (wsel)
            2'h0: w = 5'd16;
            2'h1: w = 5'd18;
            2'h2: w = 5'd20;
            2'h3: w = 5'd24;
        endcase
        sh   = 32'($signed({{8{s[23]}}, s}) >>> (5'd24 - w));
        mask = (32'h1 << w) - 32'h1;
        return ext ? sh : (sh & mask);
    endfunction

    // ==========================================================
    // Registers
    logic                  run_q;
    logic                  mute_q;
    logic                  step_sel_q;
    logic [3:0]            gain_code_q [2];
    logic                  dc_dis_q;
    logic [3:0]            coeff_q;
    logic [2:0]            tstep_q;
    logic [1:0]            width_q;
    logic                  sign_ext_q;
    logic [7:0]            thresh_q;
    logic [EV_COUNT-1:0]   status_q;
    logic [EV_COUNT-1:0]   enable_q;
    logic                  drop_q;
    logic [8:0]            applied_q [2];
    logic [9:0]            tick_cnt_q;
    logic signed [23:0]    x_prev_q [2];
    logic signed [31:0]    y_prev_q [2];

    logic                  wr_en;
    logic                  rd_done;
    logic                  setup;
    logic                  fifo_rd;
    logic                  fifo_full;
    logic                  accept;
    logic [EV_COUNT-1:0]   hw_ev;
    logic [EV_COUNT-1:0]   sw_set;
    logic [EV_COUNT-1:0]   sw_clr;
    logic [EV_COUNT-1:0]   masked;

    logic [EV_COUNT-1:0]   status_d;
    logic [EV_COUNT-1:0]   enable_d;
    logic                  rd_empty_q;

    assign setup     = psel & ~penable;
    assign wr_en     = psel & penable & pready & pwrite;
    assign rd_done   = psel & penable & pready & ~pwrite;
    assign fifo_rd   = rd_done & (paddr == ADDR_FIFO_READ);
    assign fifo_full = fifo_level >= LEVEL_W'(FIFO_DEPTH);
    assign accept    = sample_valid & run_q;
    assign masked    = status_q & enable_q;

    // ==========================================================
    // APB slave: no wait state; ready and read data are both flopped at setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (setup) begin
                unique case (paddr)
                    ADDR_CONVERTER_CONTROL: prdata <= {20'h0, gain_code_q[1], gain_code_q[0],
                                                       1'b0, step_sel_q, mute_q, run_q};
                    ADDR_MODE_CONFIG:       prdata <= {21'h0, tstep_q, coeff_q, 3'h0, dc_dis_q};
                    ADDR_DATA_FORMAT:       prdata <= {29'h0, sign_ext_q, width_q};
                    ADDR_FIFO_CONTROL:      prdata <= {24'h0, thresh_q};
                    ADDR_EVENT_STATUS:      prdata <= {28'h0, status_q};
                    ADDR_EVENT_FORCE:       prdata <= 32'h0000_0000;
                    ADDR_EVENT_ENABLE:      prdata <= {28'h0, enable_q};
                    ADDR_MASKED_VIEW:       prdata <= {28'h0, masked};
                    ADDR_FIFO_READ:         prdata <= fifo_rdata;
                    default:                pslverr <= 1'b1;
                endcase
            end
        end
    end

    // Judged at setup, with the data, so a read pops the word it returns
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_empty_q <= 1'b0;
        end else if (setup) begin
            rd_empty_q <= fifo_level == '0;
        end
    end

    // ==========================================================
    // Control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q          <= 1'b0;
            mute_q         <= 1'b0;
            step_sel_q     <= 1'b0;
            gain_code_q[0] <= GAIN_CODE_RESET;
            gain_code_q[1] <= GAIN_CODE_RESET;
            dc_dis_q       <= 1'b0;
            coeff_q        <= COEFF_RESET;
            tstep_q        <= TSTEP_RESET;
            width_q        <= WIDTH_RESET;
            sign_ext_q     <= 1'b1;
            thresh_q       <= THRESH_RESET;
            enable_q       <= '0;
        end else if (wr_en) begin
            unique case (paddr)
                ADDR_CONVERTER_CONTROL: begin
                    run_q          <= pwdata[RUN_BIT];
                    mute_q         <= pwdata[MUTE_BIT];
                    step_sel_q     <= pwdata[STEP_SEL_BIT];
                    gain_code_q[0] <= pwdata[LEFT_GAIN_LSB +: 4];
                    gain_code_q[1] <= pwdata[RIGHT_GAIN_LSB +: 4];
                end
                ADDR_MODE_CONFIG: begin
                    dc_dis_q <= pwdata[DC_DIS_BIT];
                    coeff_q  <= pwdata[COEFF_LSB +: 4];
                    tstep_q  <= pwdata[TSTEP_LSB +: 3];
                end
                ADDR_DATA_FORMAT: begin
                    width_q    <= pwdata[WIDTH_LSB +: 2];
                    sign_ext_q <= pwdata[SIGN_EXT_BIT];
                end
                ADDR_FIFO_CONTROL: thresh_q <= pwdata[7:0];
                ADDR_EVENT_ENABLE: enable_q <= pwdata[EV_COUNT-1:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Events: hardware or software set wins over a same-cycle clear
    always_comb begin
        hw_ev               = '0;
        hw_ev[EV_LEVEL]     = fifo_level > LEVEL_W'(thresh_q);
        hw_ev[EV_NOT_EMPTY] = fifo_level != '0;
        hw_ev[EV_OVERFLOW]  = accept & fifo_full;
        hw_ev[EV_UNDERFLOW] = fifo_rd & rd_empty_q;
        sw_set = (wr_en && paddr == ADDR_EVENT_FORCE) ? pwdata[EV_COUNT-1:0] : '0;
        sw_clr = (wr_en && paddr == ADDR_EVENT_STATUS) ? pwdata[EV_COUNT-1:0] : '0;
        status_d = (status_q & ~sw_clr) | hw_ev | sw_set;

        // Irq follows the next mask too, so it never lags a mask write
        enable_d = (wr_en && paddr == ADDR_EVENT_ENABLE) ? pwdata[EV_COUNT-1:0] : enable_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= '0;
        end else begin
            status_q <= status_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_d & enable_d);
        end
    end

    // Dropping stays on until software clears the overflow flag, so a
    // stream never resumes with a silent gap hidden inside it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drop_q <= 1'b0;
        end else if (accept && fifo_full) begin
            drop_q <= 1'b1;
        end else if (!status_q[EV_OVERFLOW]) begin
            drop_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fifo_pop <= 1'b0;
        end else begin
            // An empty read pops nothing; underflow reports it
            fifo_pop <= fifo_rd & ~rd_empty_q;
        end
    end

    // ==========================================================
    // Gain smoother
    logic [9:0] tick_limit;
    logic       tick;
    assign tick_limit = {tstep_q + 3'h1 == 3'h0, tstep_q + 3'h1, 6'h00} - 10'h1;
    assign tick       = accept && tick_cnt_q == tick_limit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_q <= '0;
        end else if (accept) begin
            tick_cnt_q <= tick ? 10'h000 : tick_cnt_q + 10'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            applied_q[0] <= target_idx(GAIN_CODE_RESET);
            applied_q[1] <= target_idx(GAIN_CODE_RESET);
        end else if (tick) begin
            for (int c = 0; c < 2; c++) begin
                applied_q[c] <= step_toward(applied_q[c],
                                            mute_q ? GAIN_IDX_MUTE
                                                   : target_idx(gain_code_q[c]),
                                            step_sel_q ? 9'h002 : 9'h001);
            end
        end
    end

    // ==========================================================
    // Datapath: gain, DC blocking filter, word format
    logic                ch;
    logic signed [43:0]  prod;
    logic signed [23:0]  gained;
    logic signed [33:0]  y_full;
    logic signed [23:0]  y_out;

    always_comb begin
        ch     = sample_right;
        prod   = $signed(sample_data) * $signed({1'b0, gain_mult(applied_q[ch])});
        gained = (applied_q[ch] == GAIN_IDX_MUTE) ? 24'sh0
                                                  : sat24(34'(prod >>> MULT_FRAC));
        y_full = 34'(gained) - 34'(x_prev_q[ch]) + 34'(y_prev_q[ch])
                 - 34'(y_prev_q[ch] >>> coeff_q);
        y_out  = dc_dis_q ? gained : sat24(y_full);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            x_prev_q[0] <= '0;
            x_prev_q[1] <= '0;
            y_prev_q[0] <= '0;
            y_prev_q[1] <= '0;
        end else if (!run_q) begin
            x_prev_q[0] <= '0;
            x_prev_q[1] <= '0;
            y_prev_q[0] <= '0;
            y_prev_q[1] <= '0;
        end else if (accept) begin
            x_prev_q[ch] <= gained;
            y_prev_q[ch] <= (y_full > 34'sh07FFFFFFF) ? 32'sh7FFFFFFF :
                            (y_full < -34'sh080000000) ? 32'sh80000000 : y_full[31:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fifo_push  <= 1'b0;
            fifo_wdata <= 32'h0000_0000;
        end else begin
            fifo_push <= accept & ~fifo_full & ~drop_q;
            if (accept) begin
                fifo_wdata <= format_word(y_out, width_q, sign_ext_q);
            end
        end
    end

endmodule
`default_nettype wire

// file: pcm_output_stage_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pcm_output_stage_chk
    import pcm_stage_pkg::*;
#(
    parameter int FIFO_DEPTH = 256,
    parameter int LEVEL_W    = 9
) (
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [7:0]         paddr,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire logic               sample_valid,
    input wire logic [LEVEL_W-1:0] fifo_level,
    input wire logic               fifo_push,
    input wire logic [31:0]        fifo_wdata,
    input wire logic               fifo_pop,
    input wire logic               irq
);
    // =====
    // Bus accesses that complete at this edge
    wire logic acc     = psel && penable && pready;
    wire logic rd_fifo = acc && !pwrite && paddr == ADDR_FIFO_READ;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_push_cause; fifo_push |-> $past(sample_valid); endproperty
    a_push_cause: assert property (p_push_cause) else $error("push without sample");
    property p_push_room; fifo_push |-> $past(fifo_level) < FIFO_DEPTH; endproperty
    a_push_room: assert property (p_push_room) else $error("push into full fifo");
    property p_pop_cause; fifo_pop |-> $past(rd_fifo); endproperty
    a_pop_cause: assert property (p_pop_cause) else $error("pop without read");
    // Emptiness is judged at the setup edge, two edges before the pop shows
    property p_pop_data; fifo_pop |-> $past(fifo_level, 2) != '0; endproperty
    a_pop_data: assert property (p_pop_data) else $error("pop of empty fifo");
    property p_read_pops; rd_fifo && $past(fifo_level) != '0 |=> fifo_pop; endproperty
    a_read_pops: assert property (p_read_pops) else $error("read did not pop");
    property p_fill; fifo_push |-> fifo_wdata[31:24] inside {8'h00, 8'hFF}; endproperty
    a_fill: assert property (p_fill) else $error("upper fill mixed");
    property p_irq_fall; $fell(irq) |-> $past(acc && pwrite); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without write");
    property p_wait_state; psel && !penable |=> pready ##1 !pready; endproperty
    a_wait_state: assert property (p_wait_state) else $error("bad ready timing");
    property p_err_ready; pslverr |-> pready; endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    c_push: cover property (fifo_push);
    c_pop: cover property (fifo_pop);
    c_irq: cover property ($fell(irq));
    c_err: cover property (pslverr);
endmodule
`default_nettype wire

// file: rx_fifo_model.sv
`timescale 1ns/1ps
`default_nettype none
module rx_fifo_model #(
    parameter int DEPTH   = 8,
    parameter int LEVEL_W = 9
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               fifo_push,
    input  wire logic [31:0]        fifo_wdata,
    input  wire logic               fifo_pop,
    input  wire logic               drain,
    output logic      [LEVEL_W-1:0] fifo_level,
    output logic      [31:0]        fifo_rdata
);
    // =====
    // Receive FIFO; drain stands for a DMA emptying it one word a cycle
    logic [31:0] mem_q[$];
    logic [31:0] junk_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_q.delete();
            junk_q     <= 32'hA5A55A5A;
            fifo_level <= '0;
            fifo_rdata <= '0;
        end else begin
            if ((fifo_pop || drain) && mem_q.size() > 0) begin
                void'(mem_q.pop_front());
            end
            if (fifo_push && mem_q.size() < DEPTH) begin
                mem_q.push_back(fifo_wdata);
            end
            // An empty head toggles so a stale word never reads as valid
            junk_q     <= ~junk_q;
            fifo_level <= LEVEL_W'(mem_q.size());
            fifo_rdata <= (mem_q.size() > 0) ? mem_q[0] : junk_q;
        end
    end
endmodule
`default_nettype wire

// file: pcm_output_stage_test.sv
`timescale 1ns/1ps
`default_nettype none
module pcm_output_stage_test
    import pcm_stage_pkg::*;
;
    localparam int DEPTH = 8;
    logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic                sample_valid, sample_right, fifo_push, fifo_pop, drain, err_q;
    logic [7:0]          paddr;
    logic [31:0]         pwdata, prdata, fifo_rdata, fifo_wdata, rd_q, last_word;
    logic [SAMPLE_W-1:0] sample_data;
    logic [8:0]          fifo_level;
    int                  error_cnt, tests_run, push_cnt, seed;

    pcm_output_stage #(.FIFO_DEPTH(DEPTH), .LEVEL_W(9)) dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .sample_valid, .sample_right, .sample_data, .fifo_level, .fifo_rdata,
        .fifo_push, .fifo_wdata, .fifo_pop, .irq);
    rx_fifo_model #(.DEPTH(DEPTH), .LEVEL_W(9)) u_fifo (
        .pclk, .presetn, .fifo_push, .fifo_wdata, .fifo_pop, .drain, .fifo_level, .fifo_rdata);

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        if (fifo_push === 1'b1) begin
            push_cnt  <= push_cnt + 1;
            last_word <= fifo_wdata;
        end
    end

    // =====
    // Bus, sample and compare helpers
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd_q = prdata;
        err_q = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) error_cnt++;
        @(posedge pclk);
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check($sformatf("reg %h", a), exp, rd_q);
    endtask

    task automatic send(input logic right, input logic [23:0] d);
        sample_valid <= 1'b1;
        sample_right <= right;
        sample_data  <= d;
        @(posedge pclk);
        sample_valid <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask

    function automatic logic [31:0] hi_mask(input int w);
        return ~((32'h1 << w) - 32'h1);
    endfunction

    task automatic print_verdict();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge pclk);
        error_cnt++;
        print_verdict();
    end

    initial begin
        logic [7:0]  adr [7];
        logic [31:0] rst [7];
        logic [31:0] v;
        int          w;
        int          n;
        adr = '{ADDR_CONVERTER_CONTROL, ADDR_MODE_CONFIG, ADDR_DATA_FORMAT,
                ADDR_FIFO_CONTROL, ADDR_EVENT_STATUS, ADDR_EVENT_ENABLE, ADDR_EVENT_FORCE};
        rst = '{32'h880, 32'h0B0, 32'h7, 32'h7F, 32'h0, 32'h0, 32'h0};
        seed = 32'h0001_62EF;
        {psel, penable, pwrite, sample_valid, sample_right, drain} = '0;
        {paddr, pwdata, sample_data} = '0;
        presetn = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 7; i++) rd_chk(adr[i], rst[i]);
        apb(1'b0, 8'h24, 32'h0);
        check("slverr", 32'h1, {31'h0, err_q});
        // =====
        // Software events, mask and handler clear
        apb(1'b1, ADDR_EVENT_FORCE, 32'h5);
        rd_chk(ADDR_EVENT_STATUS, 32'h5);
        rd_chk(ADDR_MASKED_VIEW, 32'h0);
        check("irq", 32'h0, {31'h0, irq});
        apb(1'b1, ADDR_EVENT_ENABLE, 32'h4);
        rd_chk(ADDR_MASKED_VIEW, 32'h4);
        check("irq", 32'h1, {31'h0, irq});
        apb(1'b0, ADDR_MASKED_VIEW, 32'h0);
        v = rd_q;
        apb(1'b1, ADDR_EVENT_STATUS, v);
        rd_chk(ADDR_EVENT_STATUS, 32'h1);
        check("irq", 32'h0, {31'h0, irq});
        apb(1'b0, ADDR_FIFO_READ, 32'h0);
        rd_chk(ADDR_EVENT_STATUS, 32'h9);
        apb(1'b1, ADDR_EVENT_STATUS, 32'hF);
        apb(1'b1, ADDR_EVENT_ENABLE, 32'hF);
        // =====
        // Word widths and fill; filter bypassed so the sign survives the gain
        apb(1'b1, ADDR_MODE_CONFIG, 32'h0B1);
        apb(1'b1, ADDR_CONVERTER_CONTROL, 32'h881);
        drain <= 1'b1;
        for (int f = 0; f < 8; f++) begin
            apb(1'b1, ADDR_DATA_FORMAT, 32'(f));
            w = (f % 4 == 3) ? 24 : 16 + 2 * (f % 4);
            for (int k = 0; k < 3; k++) begin
                v = $random(seed);
                v[22] = ~v[23];
                n = push_cnt;
                send(v[0], v[23:0]);
                check("push", 32'(n + 1), 32'(push_cnt));
                check("fill", (f > 3 && v[23]) ? hi_mask(w) : 32'h0, last_word & hi_mask(w));
                check("sign", {31'h0, v[23]}, {31'h0, last_word[w-1]});
            end
        end
        rd_chk(ADDR_EVENT_STATUS, 32'h2);
        apb(1'b1, ADDR_CONVERTER_CONTROL, 32'h880);
        n = push_cnt;
        send(1'b0, 24'h400000);
        check("push", 32'(n), 32'(push_cnt));
        // =====
        // Threshold boundary, then overflow with the far side stalled
        drain <= 1'b0;
        apb(1'b1, ADDR_EVENT_STATUS, 32'hF);
        apb(1'b1, ADDR_FIFO_CONTROL, 32'h2);
        apb(1'b1, ADDR_CONVERTER_CONTROL, 32'h881);
        n = push_cnt;
        for (int k = 1; k <= DEPTH + 2; k++) begin
            send(1'b1, 24'h400000);
            if (k == 2) rd_chk(ADDR_EVENT_STATUS, 32'h2);
            if (k == 3) rd_chk(ADDR_EVENT_STATUS, 32'h3);
        end
        check("push", 32'(n + DEPTH), 32'(push_cnt));
        apb(1'b0, ADDR_FIFO_READ, 32'h0);
        n = push_cnt;
        send(1'b1, 24'h400000);
        check("push", 32'(n), 32'(push_cnt));
        rd_chk(ADDR_EVENT_STATUS, 32'h7);
        apb(1'b1, ADDR_EVENT_STATUS, 32'h4);
        send(1'b1, 24'h400000);
        check("push", 32'(n + 1), 32'(push_cnt));
        // =====
        // With G = 0 a held input differences to zero; restart clears state
        drain <= 1'b1;
        apb(1'b1, ADDR_MODE_CONFIG, 32'h000);
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, ADDR_CONVERTER_CONTROL, 32'h880);
            apb(1'b1, ADDR_CONVERTER_CONTROL, 32'h881);
            send(1'b0, 24'h400000);
            check("hpf", 32'h1, {31'h0, last_word != 32'h0});
            send(1'b0, 24'h400000);
            check("hpf", 32'h0, last_word);
        end
        // =====
        // Soft mute with coarse step; ramp length bounds the loop count
        apb(1'b1, ADDR_MODE_CONFIG, 32'h001);
        apb(1'b1, ADDR_CONVERTER_CONTROL, 32'h887);
        n = push_cnt;
        repeat (6200) send(1'b0, 24'h400000);
        check("push", 32'(n + 6200), 32'(push_cnt));
        check("mute", 32'h0, last_word);
        apb(1'b1, ADDR_CONVERTER_CONTROL, 32'h885);
        repeat (200) send(1'b0, 24'h400000);
        check("unmute", 32'h1, {31'h0, last_word != 32'h0});
        print_verdict();
    end
endmodule

bind pcm_output_stage pcm_output_stage_chk #(.FIFO_DEPTH(FIFO_DEPTH), .LEVEL_W(LEVEL_W)) u_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready, .pslverr, .sample_valid,
    .fifo_level, .fifo_push, .fifo_wdata, .fifo_pop, .irq);
`default_nettype wire
